/* rtl/tip_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter and rise strobe.
`timescale 1ns/10ps
module tip_pin_sync (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin,
   output logic level,
   output logic rise
);
   logic s1;
   logic s2;
   logic s3;
   logic next_level;

   // A change is accepted only once stages two and three agree.
   assign next_level = (s2 == s3) ? s3 : level;
   assign rise = next_level & ~level;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         level <= 1'b0;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
         level <= next_level;
      end
   end
endmodule : tip_pin_sync

/* rtl/tip_pkg.sv */
// Package with register map, field positions and clock-select codes.
package tip_pkg;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int REG_W = 8;
   localparam int IDX_W = 10;
   localparam int CNT_W = 8;
   localparam int PRESC_W = 10;

   // Register indices; the byte address is four times the index.
   localparam logic [IDX_W-1:0] IDX_FLAG = 10'h036;
   localparam logic [IDX_W-1:0] IDX_MASK = 10'h037;
   localparam logic [IDX_W-1:0] IDX_SFC = 10'h038;
   localparam logic [IDX_W-1:0] IDX_ASR = 10'h039;
   localparam logic [IDX_W-1:0] IDX_CTRL = 10'h03a;
   localparam logic [IDX_W-1:0] IDX_CMP = 10'h03b;

   localparam logic [REG_W-1:0] REG_RST = 8'h00;
   localparam logic [CNT_W-1:0] CNT_BOTTOM = 8'h00;
   localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

   // Flag and mask share one layout.
   localparam int BIT_OVF = 0;
   localparam int BIT_CMP = 1;
   localparam int BIT_PSR_OTHERS = 0;
   localparam int BIT_PSR_T0 = 1;
   localparam int BIT_SYNC_HOLD = 7;
   localparam int BIT_ASYNC_SEL = 3;
   localparam int CS_LSB = 0;
   localparam int CS_W = 3;

   // Low counter bits that must be all ones for each divide ratio.
   localparam int DIV8_W = 3;
   localparam int DIV32_W = 5;
   localparam int DIV64_W = 6;
   localparam int DIV128_W = 7;
   localparam int DIV256_W = 8;
   localparam int DIV1024_W = 10;

   typedef enum logic [CS_W-1:0] {
      TIP_CS_STOP = 3'h0,
      TIP_CS_SRC = 3'h1,
      TIP_CS_DIV8 = 3'h2,
      TIP_CS_DIV32 = 3'h3,
      TIP_CS_DIV64 = 3'h4,
      TIP_CS_DIV128 = 3'h5,
      TIP_CS_DIV256 = 3'h6,
      TIP_CS_DIV1024 = 3'h7
   } tip_cs_t;

endpackage : tip_pkg

/* rtl/tip_presc_if.sv */
// Interface between the register block and the timer 0 prescaler.
`timescale 1ns/10ps
interface tip_presc_if;
   logic src_tick;
   logic presc_rst;
   tip_pkg::tip_cs_t cs;
   logic tick;
   logic rst_done;

   modport ctl (output src_tick, output presc_rst, output cs,
      input tick, input rst_done);
   modport presc (input src_tick, input presc_rst, input cs,
      output tick, output rst_done);
endinterface : tip_presc_if

/* rtl/tip_prescaler.sv */
// Timer 0 prescaler: free divider with selectable tap and sync reset.
`timescale 1ns/10ps
module tip_prescaler #(
   parameter int PRESC_W = tip_pkg::PRESC_W
) (
   input wire logic pclk,
   input wire logic presetn,
   tip_presc_if.presc pif
);
   logic [PRESC_W-1:0] cnt;
   logic [PRESC_W-1:0] next_cnt;
   logic tap;
   logic all8;
   logic all32;
   logic all64;
   logic all128;
   logic all256;
   logic all1024;

   assign all8 = &cnt[tip_pkg::DIV8_W-1:0];
   assign all32 = &cnt[tip_pkg::DIV32_W-1:0];
   assign all64 = &cnt[tip_pkg::DIV64_W-1:0];
   assign all128 = &cnt[tip_pkg::DIV128_W-1:0];
   assign all256 = &cnt[tip_pkg::DIV256_W-1:0];
   assign all1024 = &cnt[tip_pkg::DIV1024_W-1:0];

   assign tap = (pif.cs == tip_pkg::TIP_CS_SRC) ? 1'b1 :
      (pif.cs == tip_pkg::TIP_CS_DIV8) ? all8 :
      (pif.cs == tip_pkg::TIP_CS_DIV32) ? all32 :
      (pif.cs == tip_pkg::TIP_CS_DIV64) ? all64 :
      (pif.cs == tip_pkg::TIP_CS_DIV128) ? all128 :
      (pif.cs == tip_pkg::TIP_CS_DIV256) ? all256 :
      (pif.cs == tip_pkg::TIP_CS_DIV1024) ? all1024 : 1'b0;

   // The timer is halted for as long as the prescaler reset is held.
   assign pif.tick = pif.src_tick & ~pif.presc_rst & tap;
   // In crystal mode the reset completes on the next source edge.
   assign pif.rst_done = pif.presc_rst & pif.src_tick;

   assign next_cnt = pif.presc_rst ? '0 :
      pif.src_tick ? PRESC_W'(cnt + 1'b1) : cnt;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= '0;
      end else begin
         cnt <= next_cnt;
      end
   end
endmodule : tip_prescaler

/* rtl/tip_timer0_irq.sv */
// Timer 0 interrupt flags, enables, clock source and prescaler control.
//
// What this block does
// - Compare interrupt needs its enable and global enable.
// - Overflow interrupt needs its enable and global enable.
// - Compare flag sets when count equals compare value.
// - Compare flag clears on vector or written one.
// - Overflow flag sets on timer overflow outside PWM.
// - Overflow flag clears on vector or written one.
// - In PWM, overflow flag sets at bottom reversal.
// - Interrupt requests run only with global, enable, flag; irq summary ignores global.
// - Clock from system clock, or crystal pin when selected.
// - Async select detaches both crystal pins from port.
// - Clock choices: stop, undivided, /8 through /1024.
// - Writing prescaler reset bit restarts the prescaler.
// - Sync hold keeps prescaler resets asserted, timers halted.
// - Clearing sync hold clears both resets together.
// - Reset bit self-clears, async waits, never under hold.
`timescale 1ns/10ps
module tip_timer0_irq #(
   parameter int ADDR_W = tip_pkg::ADDR_W,
   parameter int CNT_W = tip_pkg::CNT_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [tip_pkg::DATA_W-1:0] pwdata,
   output logic [tip_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic global_irq_en,
   input wire logic [CNT_W-1:0] timer_count,
   input wire logic count_update,
   input wire logic count_down,
   input wire logic pwm_mode,
   input wire logic ovf_event,
   input wire logic vec_ack_cmp,
   input wire logic vec_ack_ovf,
   input wire logic xtal_in_pin,
   output logic timer0_tick,
   output logic prescaler_reset_others,
   output logic xtal_pins_detached,
   output logic irq_cmp_req,
   output logic irq_ovf_req,
   output logic irq
);
   localparam int RW = tip_pkg::REG_W;

   tip_presc_if pif ();

   // Register state.
   logic cmp_match_flag;
   logic ovf_flag;
   logic [RW-1:0] timer_irq_mask;
   logic sync_hold_mode;
   logic prescaler_reset_t0;
   logic async_clock_sel;
   tip_pkg::tip_cs_t clk_sel;
   logic [CNT_W-1:0] cmp_value_reg;
   logic prev_down;

   // Bus decode.
   logic [tip_pkg::IDX_W-1:0] idx;
   logic acc;
   logic setup;
   logic wr;
   logic hit_flag;
   logic hit_mask;
   logic hit_sfc;
   logic hit_asr;
   logic hit_ctrl;
   logic hit_cmp;
   logic mapped;
   logic [RW-1:0] wdata;
   logic [RW-1:0] rd_byte;
   logic [tip_pkg::DATA_W-1:0] rd_word;

   assign idx = paddr[tip_pkg::IDX_W+1:2];
   assign acc = psel & penable;
   assign setup = psel & ~penable;
   assign wr = acc & pwrite;
   assign wdata = pwdata[RW-1:0];
   assign hit_flag = (idx == tip_pkg::IDX_FLAG);
   assign hit_mask = (idx == tip_pkg::IDX_MASK);
   assign hit_sfc = (idx == tip_pkg::IDX_SFC);
   assign hit_asr = (idx == tip_pkg::IDX_ASR);
   assign hit_ctrl = (idx == tip_pkg::IDX_CTRL);
   assign hit_cmp = (idx == tip_pkg::IDX_CMP);
   assign mapped = hit_flag | hit_mask | hit_sfc | hit_asr | hit_ctrl |
      hit_cmp;

   // Every access completes at once; unmapped ones report an error.
   assign pready = 1'b1;
   assign pslverr = acc & ~mapped;

   logic wr_flag;
   logic wr_mask;
   logic wr_sfc;
   logic wr_asr;
   logic wr_ctrl;
   logic wr_cmp;

   assign wr_flag = wr & hit_flag;
   assign wr_mask = wr & hit_mask;
   assign wr_sfc = wr & hit_sfc;
   assign wr_asr = wr & hit_asr;
   assign wr_ctrl = wr & hit_ctrl;
   assign wr_cmp = wr & hit_cmp;

   // Read mux; bits with no function read as zero, except in the mask register, where all eight bits read back as written.
   logic [RW-1:0] flag_view;
   logic [RW-1:0] sfc_view;
   logic [RW-1:0] asr_view;
   logic [RW-1:0] ctrl_view;

   always_comb begin
      flag_view = tip_pkg::REG_RST;
      flag_view[tip_pkg::BIT_CMP] = cmp_match_flag;
      flag_view[tip_pkg::BIT_OVF] = ovf_flag;
      sfc_view = tip_pkg::REG_RST;
      sfc_view[tip_pkg::BIT_SYNC_HOLD] = sync_hold_mode;
      sfc_view[tip_pkg::BIT_PSR_T0] = prescaler_reset_t0;
      sfc_view[tip_pkg::BIT_PSR_OTHERS] = prescaler_reset_others;
      asr_view = tip_pkg::REG_RST;
      asr_view[tip_pkg::BIT_ASYNC_SEL] = async_clock_sel;
      ctrl_view = tip_pkg::REG_RST;
      ctrl_view[tip_pkg::CS_LSB +: tip_pkg::CS_W] = clk_sel;
   end

   assign rd_byte = hit_flag ? flag_view :
      hit_mask ? timer_irq_mask :
      hit_sfc ? sfc_view :
      hit_asr ? asr_view :
      hit_ctrl ? ctrl_view :
      hit_cmp ? RW'(cmp_value_reg) : tip_pkg::REG_RST;
   assign rd_word = {{(tip_pkg::DATA_W-RW){1'b0}}, rd_byte};

   // Read data is captured in the setup cycle and held through access.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= tip_pkg::RD_ZERO;
      end else if (setup & ~pwrite) begin
         prdata <= rd_word;
      end
   end

   // Flag events.
   logic cmp_hit;
   logic pwm_bottom;
   logic ovf_set;
   logic clr_cmp;
   logic clr_ovf;
   logic next_cmp_flag;
   logic next_ovf_flag;

   assign cmp_hit = count_update & (timer_count == cmp_value_reg);
   // Direction turns from down to up while the count sits at bottom.
   assign pwm_bottom = pwm_mode & count_update & ~count_down & prev_down &
      (timer_count == CNT_W'(tip_pkg::CNT_BOTTOM));
   assign ovf_set = (~pwm_mode & ovf_event) | pwm_bottom;
   assign clr_cmp = (wr_flag & wdata[tip_pkg::BIT_CMP]) | vec_ack_cmp;
   assign clr_ovf = (wr_flag & wdata[tip_pkg::BIT_OVF]) | vec_ack_ovf;
   // A set in the same cycle as a clear keeps the flag.
   assign next_cmp_flag = cmp_hit | (cmp_match_flag & ~clr_cmp);
   assign next_ovf_flag = ovf_set | (ovf_flag & ~clr_ovf);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_match_flag <= 1'b0;
         ovf_flag <= 1'b0;
         prev_down <= 1'b0;
      end else begin
         cmp_match_flag <= next_cmp_flag;
         ovf_flag <= next_ovf_flag;
         prev_down <= count_update ? count_down : prev_down;
      end
   end

   // Mask, clock select, async select and compare value registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_irq_mask <= tip_pkg::REG_RST;
         async_clock_sel <= 1'b0;
         clk_sel <= tip_pkg::TIP_CS_STOP;
         cmp_value_reg <= '0;
      end else begin
         if (wr_mask) begin
            timer_irq_mask <= wdata;
         end
         if (wr_asr) begin
            async_clock_sel <= wdata[tip_pkg::BIT_ASYNC_SEL];
         end
         if (wr_ctrl) begin
            clk_sel <= tip_pkg::tip_cs_t'(
               wdata[tip_pkg::CS_LSB +: tip_pkg::CS_W]);
         end
         if (wr_cmp) begin
            cmp_value_reg <= CNT_W'(wdata);
         end
      end
   end

   // Prescaler reset and synchronisation hold.
   logic hold_release;
   logic prescaler_reset_t0_done;
   logic next_hold;
   logic next_prescaler_reset_t0;
   logic next_psr_others;

   assign hold_release = wr_sfc & sync_hold_mode &
      ~wdata[tip_pkg::BIT_SYNC_HOLD];
   assign next_hold = wr_sfc ? wdata[tip_pkg::BIT_SYNC_HOLD] :
      sync_hold_mode;
   // In crystal mode the bit stays up until the reset has taken effect.
   assign prescaler_reset_t0_done = async_clock_sel ? pif.rst_done : 1'b1;
   assign next_prescaler_reset_t0 = hold_release ? 1'b0 :
      (wr_sfc & wdata[tip_pkg::BIT_PSR_T0]) ? 1'b1 :
      (prescaler_reset_t0 & ~sync_hold_mode & prescaler_reset_t0_done) ? 1'b0 :
      prescaler_reset_t0;
   assign next_psr_others = hold_release ? 1'b0 :
      (wr_sfc & wdata[tip_pkg::BIT_PSR_OTHERS]) ? 1'b1 :
      (prescaler_reset_others & ~sync_hold_mode) ? 1'b0 :
      prescaler_reset_others;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_hold_mode <= 1'b0;
         prescaler_reset_t0 <= 1'b0;
         prescaler_reset_others <= 1'b0;
      end else begin
         sync_hold_mode <= next_hold;
         prescaler_reset_t0 <= next_prescaler_reset_t0;
         prescaler_reset_others <= next_psr_others;
      end
   end

   // Clock source: every system clock, or each filtered crystal rise.
   logic xtal_rise;

   tip_pin_sync u_xtal_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin(xtal_in_pin),
      .level(),
      .rise(xtal_rise)
   );

   assign pif.src_tick = async_clock_sel ? xtal_rise : 1'b1;
   assign pif.presc_rst = prescaler_reset_t0;
   assign pif.cs = clk_sel;

   tip_prescaler u_presc (
      .pclk(pclk),
      .presetn(presetn),
      .pif(pif)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer0_tick <= 1'b0;
      end else begin
         timer0_tick <= pif.tick;
      end
   end

   assign xtal_pins_detached = async_clock_sel;

   // Interrupt requests to the core and the summary line.
   logic [RW-1:0] pend;

   assign irq_cmp_req = cmp_match_flag & global_irq_en &
      timer_irq_mask[tip_pkg::BIT_CMP];
   assign irq_ovf_req = ovf_flag & global_irq_en &
      timer_irq_mask[tip_pkg::BIT_OVF];
   assign pend = flag_view & timer_irq_mask;
   assign irq = |pend;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   AST_CMP_REQ: assert property (
      (cmp_hit ##1 (global_irq_en && timer_irq_mask[tip_pkg::BIT_CMP]))
         |-> irq_cmp_req)
      else $error("compare request missing after match");

   AST_OVF_REQ: assert property (
      (ovf_set ##1 (global_irq_en && timer_irq_mask[tip_pkg::BIT_OVF]))
         |-> irq_ovf_req)
      else $error("overflow request missing");

   AST_CMP_SET: assert property (
      (count_update && timer_count == cmp_value_reg) |=> cmp_match_flag)
      else $error("compare flag not set on match");

   AST_CMP_CLR: assert property (
      (vec_ack_cmp && !cmp_hit) |=> !cmp_match_flag)
      else $error("compare flag not cleared by vector");

   AST_OVF_SET: assert property (
      (ovf_event && !pwm_mode) |=> ovf_flag)
      else $error("overflow flag not set");

   AST_OVF_W1C: assert property (
      (wr_flag && wdata[tip_pkg::BIT_OVF] && !ovf_set) |=> !ovf_flag)
      else $error("overflow flag not cleared by write one");

   AST_PWM_BOT: assert property (
      (pwm_mode && count_update && !count_down && prev_down &&
         timer_count == CNT_W'(tip_pkg::CNT_BOTTOM)) |=> ovf_flag)
      else $error("overflow flag not set at bottom turn");

   AST_SRC_CLK: assert property (
      (!async_clock_sel && clk_sel == tip_pkg::TIP_CS_SRC &&
         !prescaler_reset_t0) |=> timer0_tick)
      else $error("undivided system clock tick missing");

   AST_DETACH: assert property (
      $rose(async_clock_sel) |-> xtal_pins_detached)
      else $error("crystal pins not detached");

   AST_STOP: assert property (
      (clk_sel == tip_pkg::TIP_CS_STOP && !wr_ctrl) |=> !timer0_tick [*2])
      else $error("tick while stopped");

   AST_HOLD: assert property (
      (sync_hold_mode && prescaler_reset_t0 && !wr_sfc) |=>
         prescaler_reset_t0 && !timer0_tick)
      else $error("prescaler reset not held");

   AST_RELEASE: assert property (
      hold_release |=> !prescaler_reset_t0 && !prescaler_reset_others)
      else $error("resets not cleared on hold release");

   AST_SELF_CLR: assert property (
      (prescaler_reset_t0 && !sync_hold_mode && !async_clock_sel &&
         !wr_sfc) |=> !prescaler_reset_t0)
      else $error("prescaler reset did not self-clear");

endmodule : tip_timer0_irq

/* tb/tb_top.sv */
// Testbench for the timer 0 interrupt and prescaler block.
`timescale 1ns/10ps
module tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic gie, cupd, cdown, pwm, ovf, xtal, xrun, ack_on;
   logic [7:0] tcnt;
   logic [3:0] ack_delay, xdiv;
   logic ack_cmp, ack_ovf, tick, pro, detached, rc, ro, irq;
   int check_count, fail_count, ticks, t0, d1, d2, n;
   int exp_t[8] = '{0, 2048, 256, 64, 32, 16, 8, 2};

   tip_timer0_irq dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .global_irq_en(gie), .timer_count(tcnt), .count_update(cupd),
      .count_down(cdown), .pwm_mode(pwm), .ovf_event(ovf),
      .vec_ack_cmp(ack_cmp), .vec_ack_ovf(ack_ovf), .xtal_in_pin(xtal),
      .timer0_tick(tick), .prescaler_reset_others(pro),
      .xtal_pins_detached(detached), .irq_cmp_req(rc), .irq_ovf_req(ro),
      .irq(irq));

   tip_cpu_model cpu (.pclk(pclk), .presetn(presetn), .ack_on(ack_on),
      .ack_delay(ack_delay), .irq_cmp_req(rc), .irq_ovf_req(ro),
      .vec_ack_cmp(ack_cmp), .vec_ack_ovf(ack_ovf));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // Ticks are counted on the falling edge, away from the sampling edge.
   always @(negedge pclk) begin
      if (tick === 1'b1) begin
         ticks++;
      end
   end

   // Crystal with a period of ten bus clocks, stopped while xrun is low.
   always @(posedge pclk) begin
      if (xrun) begin
         xdiv <= (xdiv == 4'h4) ? 4'h0 : xdiv + 4'h1;
         if (xdiv == 4'h4) begin
            xtal <= ~xtal;
         end
      end
   end

   task automatic chk(input string what, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [9:0] idx,
         input logic [31:0] wd);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      if (k >= 16) begin
         fail_count++;
      end
      rd = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
      apb(1'b1, idx, wd);
   endtask : wr

   task automatic rdc(input string what, input logic [9:0] idx,
         input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk(what, rd, exp);
   endtask : rdc

   task automatic ev(input logic [7:0] c, input logic dn, u, o);
      @(posedge pclk);
      tcnt <= c;
      cdown <= dn;
      cupd <= u;
      ovf <= o;
      @(posedge pclk);
      cupd <= 1'b0;
      ovf <= 1'b0;
   endtask : ev

   task automatic wait_irq_low();
      n = 0;
      while (irq !== 1'b0 && n < 80) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 80) begin
         fail_count++;
      end
   endtask : wait_irq_low

   task automatic wait_tick(output int d);
      d = 2;
      // Skip a tick that may already be in flight from before the write.
      repeat (2) @(posedge pclk);
      while (tick !== 1'b1 && d < 300) begin
         @(posedge pclk);
         d++;
      end
      if (d >= 300) begin
         fail_count++;
      end
   endtask : wait_tick

   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : wrap_up

   initial begin
      repeat (40000) @(posedge pclk);
      fail_count++;
      wrap_up();
   end

   initial begin
      {presetn, psel, penable, pwrite, gie, cupd, cdown, pwm} = 8'h00;
      {ovf, xtal, xrun, ack_on} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      tcnt = 8'h00;
      ack_delay = 4'h0;
      xdiv = 4'h0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rdc("flag reset", tip_pkg::IDX_FLAG, 32'h0);
      rdc("mask reset", tip_pkg::IDX_MASK, 32'h0);
      apb(1'b0, 10'h000, 32'h0);
      chk("unmapped err", {31'h0, last_err}, 32'h1);
      chk("unmapped data", rd, 32'h0);
      wr(tip_pkg::IDX_MASK, 32'ha5);
      rdc("mask rw", tip_pkg::IDX_MASK, 32'ha5);
      wr(tip_pkg::IDX_CMP, 32'h42);
      ev(8'h41, 1'b0, 1'b1, 1'b0);
      rdc("flag no match", tip_pkg::IDX_FLAG, 32'h0);
      ev(8'h42, 1'b0, 1'b1, 1'b1);
      rdc("flags set", tip_pkg::IDX_FLAG, 32'h3);
      for (int i = 0; i < 4; i++) begin
         gie <= i[0];
         wr(tip_pkg::IDX_MASK, i[1] ? 32'h3 : 32'h0);
         @(posedge pclk);
         chk("cmp req", {31'h0, rc}, 32'(i == 3));
         chk("ovf req", {31'h0, ro}, 32'(i == 3));
         chk("irq", {31'h0, irq}, 32'(i[1]));
      end
      ack_on <= 1'b1;
      wait_irq_low();
      rdc("flag vector clr", tip_pkg::IDX_FLAG, 32'h0);
      ack_on <= 1'b0;
      ev(8'h42, 1'b0, 1'b1, 1'b1);
      wr(tip_pkg::IDX_FLAG, 32'h0);
      rdc("w1c zero", tip_pkg::IDX_FLAG, 32'h3);
      wr(tip_pkg::IDX_FLAG, 32'h1);
      rdc("w1c ovf", tip_pkg::IDX_FLAG, 32'h2);
      wr(tip_pkg::IDX_FLAG, 32'h2);
      rdc("w1c cmp", tip_pkg::IDX_FLAG, 32'h0);
      pwm <= 1'b1;
      ev(8'h10, 1'b0, 1'b0, 1'b1);
      ev(8'h01, 1'b1, 1'b1, 1'b0);
      ev(8'h00, 1'b1, 1'b1, 1'b0);
      rdc("pwm no ovf", tip_pkg::IDX_FLAG, 32'h0);
      ev(8'h00, 1'b0, 1'b1, 1'b0);
      rdc("pwm turn", tip_pkg::IDX_FLAG, 32'h1);
      ack_delay <= 4'hc;
      ack_on <= 1'b1;
      wait_irq_low();
      rdc("slow vector", tip_pkg::IDX_FLAG, 32'h0);
      {ack_on, pwm} <= 2'b00;
      for (int i = 0; i < 8; i++) begin
         wr(tip_pkg::IDX_CTRL, 32'(i));
         repeat (8) @(posedge pclk);
         t0 = ticks;
         repeat (2048) @(posedge pclk);
         chk("tick rate", 32'(ticks - t0),
            32'(exp_t[i]));
      end
      wr(tip_pkg::IDX_CTRL, 32'(tip_pkg::TIP_CS_DIV64));
      wr(tip_pkg::IDX_SFC, 32'h2);
      wait_tick(d1);
      repeat (13) @(posedge pclk);
      wr(tip_pkg::IDX_SFC, 32'h2);
      wait_tick(d2);
      chk("reset phase", 32'(d1), 32'(d2));
      rdc("psr self clr", tip_pkg::IDX_SFC, 32'h0);
      wr(tip_pkg::IDX_SFC, 32'h83);
      t0 = ticks;
      repeat (200) @(posedge pclk);
      chk("held ticks", 32'(ticks - t0), 32'h0);
      chk("others rst", {31'h0, pro}, 32'h1);
      rdc("hold kept", tip_pkg::IDX_SFC, 32'h83);
      wr(tip_pkg::IDX_SFC, 32'h0);
      repeat (2) @(posedge pclk);
      chk("others free", {31'h0, pro}, 32'h0);
      rdc("hold off", tip_pkg::IDX_SFC, 32'h0);
      t0 = ticks;
      repeat (128) @(posedge pclk);
      chk("resumed", 32'(ticks - t0), 32'h2);
      wr(tip_pkg::IDX_ASR, 32'h8);
      @(posedge pclk);
      chk("detached", {31'h0, detached}, 32'h1);
      wr(tip_pkg::IDX_CTRL, 32'(tip_pkg::TIP_CS_SRC));
      wr(tip_pkg::IDX_SFC, 32'h2);
      repeat (20) @(posedge pclk);
      rdc("async psr wait", tip_pkg::IDX_SFC, 32'h2);
      xrun <= 1'b1;
      repeat (40) @(posedge pclk);
      rdc("async psr done", tip_pkg::IDX_SFC, 32'h0);
      t0 = ticks;
      repeat (400) @(posedge pclk);
      d1 = ticks - t0;
      chk("xtal ticks", 32'(d1 >= 39 && d1 <= 41), 32'h1);
      xrun <= 1'b0;
      wr(tip_pkg::IDX_ASR, 32'h0);
      @(posedge pclk);
      chk("attached", {31'h0, detached}, 32'h0);
      wrap_up();
   end
endmodule : tb_top

/* tb/tip_cpu_model.sv */
// CPU interrupt vectoring model that acknowledges requests after a delay.
`timescale 1ns/10ps
module tip_cpu_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ack_on,
   input wire logic [3:0] ack_delay,
   input wire logic irq_cmp_req,
   input wire logic irq_ovf_req,
   output logic vec_ack_cmp,
   output logic vec_ack_ovf
);
   logic [3:0] wait_cnt;
   logic busy;

   // After a vector the model stays quiet for a cycle while the flag drops.
   assign busy = vec_ack_cmp | vec_ack_ovf;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_cnt <= 4'h0;
         vec_ack_cmp <= 1'b0;
         vec_ack_ovf <= 1'b0;
      end else begin
         vec_ack_cmp <= 1'b0;
         vec_ack_ovf <= 1'b0;
         wait_cnt <= 4'h0;
         if (ack_on && !busy && (irq_cmp_req || irq_ovf_req)) begin
            wait_cnt <= wait_cnt + 4'h1;
            if (wait_cnt == ack_delay) begin
               vec_ack_cmp <= irq_cmp_req;
               vec_ack_ovf <= !irq_cmp_req;
            end
         end
      end
   end
endmodule : tip_cpu_model
